// File: gated_timer_pkg.sv
package gated_timer_pkg;

  // ------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_PERIOD = 3'h1;
  localparam logic [2:0] ADDR_COUNT = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h3;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;

  // ------------------------------------------------------------
  // Control register field positions
  // ------------------------------------------------------------
  localparam int BIT_RUN = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_GATE_EN = 6;
  localparam int BIT_PRESCALE_HI = 5;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_EXT_SYNC = 2;
  localparam int BIT_SRC_EXT = 1;

  // ------------------------------------------------------------
  // Interrupt status layout and reset values
  // ------------------------------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_BIT_MATCH = 0;
  localparam int IRQ_BIT_GATE_FALL = 1;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Prescale terminal counts (ratio minus one)
  // ------------------------------------------------------------
  localparam int PRE_W = 8;
  localparam logic [7:0] PRE_LAST_1 = 8'h00;
  localparam logic [7:0] PRE_LAST_8 = 8'h07;
  localparam logic [7:0] PRE_LAST_64 = 8'h3f;
  localparam logic [7:0] PRE_LAST_256 = 8'hff;

  typedef enum logic [1:0] {
    PRE_DIV1 = 2'b00,
    PRE_DIV8 = 2'b01,
    PRE_DIV64 = 2'b10,
    PRE_DIV256 = 2'b11
  } prescale_select_t;

  typedef struct packed {
    logic timerRun;
    logic idleStop;
    logic gateAccumulateEn;
    prescale_select_t prescaleSelect;
    logic extClockSync;
    logic clockSourceSelect;
  } timer_control_t;

  localparam timer_control_t CONTROL_RESET = '{1'b0, 1'b0, 1'b0, PRE_DIV1, 1'b0, 1'b0};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } reg_req_t;

endpackage

// File: sixteen_bit_gated_timer.sv
`timescale 1ns/1ps

// What this block does
// R1: A 16-bit counter runs as internal timer, synchronous counter or unsynchronised counter.
// R2: An interrupt is raised on a period match and, in gated mode, on the gate's falling edge.
// R3: Control bit 15 starts counting when 1 and stops it when 0.
// R4: With control bit 13 set the timer halts in Idle, otherwise it keeps running in Idle.
// R5: Control bit 6 enables gated accumulation only while the internal clock is selected.
// R6: Prescale bits 5-4 divide the input by 1, 8, 64 or 256 for codes 00, 01, 10, 11.
// R7: With the external clock, bit 2 chooses synchronised or unsynchronised counting.
// R8: Control bit 1 selects external rising edges when 1 and the internal half-rate clock when 0.
// R9: Control bits 14, 12-7, 3 and 0 ignore writes and read as zero.
// R10: A control write while running resets the prescale counter; software should avoid it.
// R11: All control bits clear at reset: stopped, internal clock, 1:1 prescale.
// R12: The timer can keep counting in Idle or Sleep to serve as a real-time clock base.
// R13: Software sets up prescale, source, gate, sync and period before enabling interrupts.
// R14: The increment after a period match returns the count to zero and sets the match flag.
// R15: In gated mode the count advances on prescaled internal ticks only while the gate is high.
module sixteen_bit_gated_timer #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire gated_timer_pkg::reg_req_t regReq,
  output logic [gated_timer_pkg::DATA_W-1:0] rdData,
  input wire logic extClockPin,
  input wire logic gatePin,
  input wire logic idleMode,
  input wire logic sleepMode,
  output logic timerIrq
);
  import gated_timer_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic extMeta_q, extSync_q, extPrev_q;
  logic gateMeta_q, gateSync_q, gatePrev_q;

  // Count pin: two flops, the third only feeds the edge detector
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      extMeta_q <= 1'b0;
      extSync_q <= 1'b0;
      extPrev_q <= 1'b0;
    end else begin
      extMeta_q <= extClockPin;
      extSync_q <= extMeta_q;
      extPrev_q <= extSync_q;
    end
  end

  // Gate pin: resets low so no false fall follows reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gateMeta_q <= 1'b0;
      gateSync_q <= 1'b0;
      gatePrev_q <= 1'b0;
    end else begin
      gateMeta_q <= gatePin;
      gateSync_q <= gateMeta_q;
      gatePrev_q <= gateSync_q;
    end
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  timer_control_t control_q, control_d;
  logic [WIDTH-1:0] period_q, period_d;
  logic [WIDTH-1:0] count_q, count_d;
  logic [IRQ_W-1:0] irqStatus_q, irqStatus_d;
  logic [IRQ_W-1:0] irqMask_q, irqMask_d;
  logic [PRE_W-1:0] prescale_q, prescale_d;
  logic halfRate_q, halfRate_d;
  logic [DATA_W-1:0] rdData_q, rdData_d;
  logic irq_q, irq_d;

  logic wrControl, wrPeriod, wrCount, wrStatus, wrMask;
  logic extRise, gateFall, gateOpen;
  logic sourceTick, halted, preTick, countTick, matchHit;
  logic [PRE_W-1:0] preLast;

  // ------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------
  assign wrControl = regReq.wrStrobe && (regReq.addr == ADDR_CONTROL);
  assign wrPeriod = regReq.wrStrobe && (regReq.addr == ADDR_PERIOD);
  assign wrCount = regReq.wrStrobe && (regReq.addr == ADDR_COUNT);
  assign wrStatus = regReq.wrStrobe && (regReq.addr == ADDR_IRQ_STATUS);
  assign wrMask = regReq.wrStrobe && (regReq.addr == ADDR_IRQ_MASK);

  assign extRise = extSync_q && !extPrev_q;
  assign gateFall = gatePrev_q && !gateSync_q;

  // ------------------------------------------------------------
  // Count source, prescaler and period compare
  // ------------------------------------------------------------
  always_comb begin
    // Gate only matters on the internal clock
    gateOpen = 1'b1;
    if (!control_q.clockSourceSelect && control_q.gateAccumulateEn) begin
      gateOpen = gateSync_q; // [R5] [R15]
    end
    // Internal tick is half the core rate
    sourceTick = halfRate_q; // [R8]
    if (control_q.clockSourceSelect) begin
      sourceTick = extRise; // [R8]
    end
    // Sleep stops the core clock path; only the unsynchronised counter survives it
    halted = !control_q.timerRun; // [R3]
    if (idleMode && control_q.idleStop) begin
      halted = 1'b1; // [R4]
    end
    if (sleepMode && !(control_q.clockSourceSelect && !control_q.extClockSync)) begin
      halted = 1'b1; // [R7] [R12]
    end
    case (control_q.prescaleSelect)
      PRE_DIV1: preLast = PRE_LAST_1; // [R6]
      PRE_DIV8: preLast = PRE_LAST_8; // [R6]
      PRE_DIV64: preLast = PRE_LAST_64; // [R6]
      PRE_DIV256: preLast = PRE_LAST_256; // [R6]
      default: preLast = PRE_LAST_1;
    endcase
    preTick = !halted && sourceTick && gateOpen && (prescale_q == preLast);
    countTick = preTick;
    matchHit = countTick && (count_q == period_q); // [R2]
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_comb begin
    control_d = control_q;
    if (wrControl) begin
      // Unimplemented bits are simply never stored
      control_d.timerRun = regReq.wrData[BIT_RUN]; // [R3] [R9]
      control_d.idleStop = regReq.wrData[BIT_IDLE_STOP]; // [R4]
      control_d.gateAccumulateEn = regReq.wrData[BIT_GATE_EN]; // [R5]
      control_d.prescaleSelect =
        prescale_select_t'(regReq.wrData[BIT_PRESCALE_HI:BIT_PRESCALE_LO]); // [R6]
      control_d.extClockSync = regReq.wrData[BIT_EXT_SYNC]; // [R7]
      control_d.clockSourceSelect = regReq.wrData[BIT_SRC_EXT]; // [R8]
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_q <= CONTROL_RESET; // [R11]
    end else begin
      control_q <= control_d;
    end
  end

  // ------------------------------------------------------------
  // Period register
  // ------------------------------------------------------------
  always_comb begin
    period_d = period_q;
    if (wrPeriod) begin
      period_d = regReq.wrData[WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      period_q <= PERIOD_RESET;
    end else begin
      period_q <= period_d;
    end
  end

  // ------------------------------------------------------------
  // Prescaler and half-rate tick
  // ------------------------------------------------------------
  always_comb begin
    prescale_d = prescale_q;
    halfRate_d = !halfRate_q;
    // Prescaler advances on each qualified source tick
    if (!halted && sourceTick && gateOpen) begin
      if (prescale_q == preLast) begin
        prescale_d = '0;
      end else begin
        prescale_d = prescale_q + 1'b1; // [R6]
      end
    end
    // Reconfiguring a live timer restarts the division cleanly
    if (wrControl && control_q.timerRun) begin
      prescale_d = '0; // [R10]
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_q <= '0;
      halfRate_q <= 1'b0;
    end else begin
      prescale_q <= prescale_d;
      halfRate_q <= halfRate_d;
    end
  end

  // ------------------------------------------------------------
  // Count register
  // ------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    if (matchHit) begin
      count_d = '0; // [R14]
    end else if (countTick) begin
      count_d = count_q + 1'b1; // [R1]
    end
    // Software load of the count takes priority over counting
    if (wrCount) begin
      count_d = regReq.wrData[WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  always_comb begin
    irqStatus_d = irqStatus_q;
    irqMask_d = irqMask_q;
    if (wrMask) begin
      irqMask_d = regReq.wrData[IRQ_W-1:0];
    end
    // Write-one-to-clear; a new event in the same cycle wins
    if (wrStatus) begin
      irqStatus_d = irqStatus_q & ~regReq.wrData[IRQ_W-1:0];
    end
    if (matchHit) begin
      irqStatus_d[IRQ_BIT_MATCH] = 1'b1; // [R2] [R14]
    end
    if (gateFall && control_q.timerRun && control_q.gateAccumulateEn &&
        !control_q.clockSourceSelect) begin
      irqStatus_d[IRQ_BIT_GATE_FALL] = 1'b1; // [R2]
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus_q <= '0;
      irqMask_q <= '0;
    end else begin
      irqStatus_q <= irqStatus_d;
      irqMask_q <= irqMask_d;
    end
  end

  // ------------------------------------------------------------
  // Interrupt output
  // ------------------------------------------------------------
  always_comb begin
    // Built from next values so the pin rises with its status bit
    irq_d = |(irqStatus_d & irqMask_d); // [R2]
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb begin
    rdData_d = '0;
    if (regReq.rdStrobe) begin
      case (regReq.addr)
        ADDR_CONTROL: begin
          rdData_d[BIT_RUN] = control_q.timerRun; // [R9]
          rdData_d[BIT_IDLE_STOP] = control_q.idleStop;
          rdData_d[BIT_GATE_EN] = control_q.gateAccumulateEn;
          rdData_d[BIT_PRESCALE_HI:BIT_PRESCALE_LO] = control_q.prescaleSelect;
          rdData_d[BIT_EXT_SYNC] = control_q.extClockSync;
          rdData_d[BIT_SRC_EXT] = control_q.clockSourceSelect;
        end
        ADDR_PERIOD: rdData_d[WIDTH-1:0] = period_q;
        ADDR_COUNT: rdData_d[WIDTH-1:0] = count_q;
        ADDR_IRQ_STATUS: rdData_d[IRQ_W-1:0] = irqStatus_q;
        ADDR_IRQ_MASK: rdData_d[IRQ_W-1:0] = irqMask_q;
        default: rdData_d = '0;
      endcase
    end
  end

  // Answer stands one cycle only; zero keeps idle reads harmless
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign rdData = rdData_q;
  assign timerIrq = irq_q;

endmodule

// File: gated_timer_asserts.sv
`timescale 1ns/1ps
// ----------------------
// Register port checks
// ----------------------
module gated_timer_asserts
  import gated_timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire gated_timer_pkg::reg_req_t regReq,
  input wire logic [gated_timer_pkg::DATA_W-1:0] rdData,
  input wire logic extClockPin,
  input wire logic gatePin,
  input wire logic idleMode,
  input wire logic sleepMode,
  input wire logic timerIrq
);
  logic [15:0] ctrlShadow_q;
  logic [15:0] periodShadow_q;
  logic [1:0] maskShadow_q;
  // Shadows track software writes only, never the design's state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlShadow_q <= 16'h0000;
      periodShadow_q <= PERIOD_RESET;
      maskShadow_q <= 2'h0;
    end else if (regReq.wrStrobe) begin
      if (regReq.addr == ADDR_CONTROL) ctrlShadow_q <= regReq.wrData & 16'ha076;
      if (regReq.addr == ADDR_PERIOD) periodShadow_q <= regReq.wrData;
      if (regReq.addr == ADDR_IRQ_MASK) maskShadow_q <= regReq.wrData[1:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_RD_IDLE: assert property (!$past(regReq.rdStrobe) |-> rdData == 16'h0000)
    else $error("read data not zero outside a read answer");
  AST_CTRL_RB: assert property ($past(regReq.rdStrobe && regReq.addr == ADDR_CONTROL)
    |-> rdData == $past(ctrlShadow_q)) else $error("control read back wrong");
  AST_PERIOD_RB: assert property ($past(regReq.rdStrobe && regReq.addr == ADDR_PERIOD)
    |-> rdData == $past(periodShadow_q)) else $error("period read back wrong");
  AST_MASK_RB: assert property ($past(regReq.rdStrobe && regReq.addr == ADDR_IRQ_MASK)
    |-> rdData == {14'h0000, $past(maskShadow_q)}) else $error("mask read back wrong");
  AST_UNMAPPED: assert property ($past(regReq.rdStrobe && regReq.addr > ADDR_IRQ_MASK)
    |-> rdData == 16'h0000) else $error("unmapped read not zero");
  AST_STATUS_W: assert property ($past(regReq.rdStrobe && regReq.addr == ADDR_IRQ_STATUS)
    |-> rdData[15:2] == 14'h0000) else $error("status spare bits set");
  AST_MASK_OFF: assert property (regReq.wrStrobe && regReq.addr == ADDR_IRQ_MASK
    && regReq.wrData[1:0] == 2'h0 |=> !timerIrq) else $error("irq high with mask clear");
  AST_IRQ_MASKED: assert property ($rose(timerIrq) |-> maskShadow_q != 2'h0)
    else $error("irq rose with no unmasked source");
endmodule
bind sixteen_bit_gated_timer gated_timer_asserts chk_u (.sys_clk(sys_clk), .arst_n(arst_n),
  .regReq(regReq), .rdData(rdData), .extClockPin(extClockPin), .gatePin(gatePin),
  .idleMode(idleMode), .sleepMode(sleepMode), .timerIrq(timerIrq));

// File: ext_pin_model.sv
`timescale 1ns/1ps
// ------------------------------
// External count pin burst model
// ------------------------------
module ext_pin_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [7:0] pulses,
  output logic extClockPin
);
  logic [7:0] left_q = 8'h00;
  logic [2:0] ph_q = 3'h0;
  // Pin rests low between bursts, like a pulled-down input
  always @(posedge sys_clk) begin
    if (go) begin
      left_q <= pulses;
      ph_q <= 3'h0;
    end else if (left_q != 8'h00) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
  // Four cycles high, four low: one rising edge per pulse
  assign extClockPin = (left_q != 8'h00) && ph_q[2];
endmodule

// File: sixteen_bit_gated_timer_bench.sv
`timescale 1ns/1ps
// -----------------
// Timer testbench
// -----------------
module sixteen_bit_gated_timer_bench;
  import gated_timer_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_t regReq = '0;
  logic [DATA_W-1:0] rdData;
  logic extClockPin, timerIrq, gatePin = 1'b0, idleMode = 1'b0, sleepMode = 1'b0;
  logic go = 1'b0;
  logic [7:0] pulses = 8'h00;
  logic [15:0] v;
  int failures = 0;
  int n_tests = 0;
  int rat[4] = '{1, 8, 64, 256};
  logic [15:0] rst[6] = '{16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  always #50 sys_clk = ~sys_clk;
  sixteen_bit_gated_timer dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .regReq(regReq),
    .rdData(rdData), .extClockPin(extClockPin), .gatePin(gatePin), .idleMode(idleMode),
    .sleepMode(sleepMode), .timerIrq(timerIrq));
  ext_pin_model pin_u (.sys_clk(sys_clk), .go(go), .pulses(pulses), .extClockPin(extClockPin));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic inr(input string nm, input logic [15:0] s, input int lo, input int hi);
    chk(nm, {15'h0000, (s >= lo && s <= hi)}, 16'h0001);
  endtask
  // One idle cycle after each strobe keeps a strobe from being driven twice in a step
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    regReq.addr <= a;
    regReq.wrData <= d;
    regReq.wrStrobe <= 1'b1;
    @(posedge sys_clk);
    regReq.wrStrobe <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    regReq.addr <= a;
    regReq.rdStrobe <= 1'b1;
    @(posedge sys_clk);
    regReq.rdStrobe <= 1'b0;
    #1 d = rdData;
    @(posedge sys_clk);
  endtask
  task automatic run(input logic [15:0] c, input int n, input logic [7:0] p);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_CONTROL, c);
    pulses <= p;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (p * 8 + n) @(posedge sys_clk);
    wr(ADDR_CONTROL, 16'h0000);
    rd(ADDR_COUNT, v);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      rd(i == 5 ? 3'h7 : 3'(i), v);
      chk("reset", v, rst[i]);
    end
    wr(ADDR_CONTROL, 16'hffff);
    rd(ADDR_CONTROL, v);
    chk("ctrl", v, 16'ha076);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_PERIOD, 16'h0002);
    wr(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_CONTROL, 16'h8000);
    for (int i = 0; i < 40 && timerIrq !== 1'b1; i++) @(posedge sys_clk);
    chk("irq", {15'h0000, timerIrq}, 16'h0001);
    if (timerIrq !== 1'b1) end_sim();
    rd(ADDR_COUNT, v);
    inr("wrap", v, 0, 2);
    wr(ADDR_CONTROL, 16'h0000);
    rd(ADDR_IRQ_STATUS, v);
    chk("match", v, 16'h0001);
    wr(ADDR_IRQ_STATUS, 16'h0001);
    rd(ADDR_IRQ_STATUS, v);
    chk("w1c", {v[14:0], timerIrq}, 16'h0000);
    wr(ADDR_PERIOD, 16'hffff);
    for (int k = 0; k < 4; k++) begin
      run(16'h8000 | 16'(k << 4), rat[k] * 8 - 2, 8'h00);
      inr("prescale", v, 3, 5);
    end
    idleMode <= 1'b1;
    run(16'ha000, 40, 8'h00);
    chk("idlestop", v, 16'h0000);
    run(16'h8000, 40, 8'h00);
    inr("idlerun", v, 19, 23);
    idleMode <= 1'b0;
    run(16'h8042, 6, 8'h05);
    chk("ext", v, 16'h0005);
    sleepMode <= 1'b1;
    run(16'h8006, 6, 8'h04);
    chk("syncsleep", v, 16'h0000);
    run(16'h8002, 6, 8'h04);
    chk("asyncsleep", v, 16'h0004);
    sleepMode <= 1'b0;
    run(16'h8040, 20, 8'h00);
    chk("gatelow", v, 16'h0000);
    wr(ADDR_CONTROL, 16'h8040);
    gatePin <= 1'b1;
    repeat (20) @(posedge sys_clk);
    gatePin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    wr(ADDR_CONTROL, 16'h0000);
    rd(ADDR_COUNT, v);
    inr("gated", v, 9, 11);
    rd(ADDR_IRQ_STATUS, v);
    chk("gatefall", {v[14:0], timerIrq}, 16'h0004);
    wr(ADDR_IRQ_MASK, 16'h0003);
    chk("unmasked", {15'h0000, timerIrq}, 16'h0001);
    wr(ADDR_IRQ_STATUS, 16'h0002);
    chk("cleared", {15'h0000, timerIrq}, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0000);
    end_sim();
  end
endmodule
